// ---- rtl/irc_pkg.sv ----
// Package for the interrupt and reset control block.
// Assumes an 8-bit register port and a 16-bit vector address space.
package irc_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] ADDR_PIN_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PRIO = 4'h1;
    localparam logic [3:0] ADDR_WDOG_SVC = 4'h2;
    localparam logic [3:0] ADDR_WDOG_CTRL = 4'h3;
    localparam logic [3:0] ADDR_RST_STAT = 4'h4;
    localparam logic [3:0] ADDR_PEND_LO = 4'h5;
    localparam logic [3:0] ADDR_PEND_MID = 4'h6;
    localparam logic [3:0] ADDR_PEND_HI = 4'h7;
    localparam logic [3:0] ADDR_FLAG_CLR_LO = 4'h8;
    localparam logic [3:0] ADDR_FLAG_CLR_MID = 4'h9;
    localparam logic [3:0] ADDR_FLAG_CLR_HI = 4'hA;
    // Pin control field positions
    localparam int BIT_EDGE = 7;
    localparam int BIT_CONNECT = 6;
    localparam int BIT_DELAY = 5;
    localparam logic [7:0] PIN_CTRL_RST = 8'h60;
    localparam logic [7:0] PRIO_RST = 8'hF2;
    // Watchdog control: bit 7 enable, bit 6 clock monitor, bit 5 forced monitor
    localparam logic [7:0] WDOG_CTRL_RST = 8'h80;
    localparam logic [7:0] WDOG_KEY1 = 8'h55;
    localparam logic [7:0] WDOG_KEY2 = 8'hAA;
    // Vectors
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
    localparam logic [15:0] VEC_WDOG = 16'hFFFA;
    localparam logic [15:0] VEC_TRAP = 16'hFFF8;
    localparam logic [15:0] VEC_NMI = 16'hFFF4;
    localparam logic [7:0] VEC_HI_BYTE = 8'hFF;
    localparam logic [7:0] LOW_EXT_PIN = 8'hF2;
    localparam logic [7:0] LOW_TOP = 8'hF0;
    localparam logic [7:0] LOW_RESERVED_D4 = 8'hD4;
    localparam logic [7:0] LOW_FLOOR = 8'hC2;
    // Peripheral source count: F0 down to C2, one per word
    localparam int NSRC = 24;
    // Reset pin timing in E-clocks
    localparam int RST_DRIVE_CYC = 16;
    localparam int RST_SAMPLE_CYC = 8;
    localparam int STOP_DELAY_CYC = 4096;
    // Reset cause codes
    localparam logic [1:0] CAUSE_EXT = 2'h0;
    localparam logic [1:0] CAUSE_WDOG = 2'h1;
    localparam logic [1:0] CAUSE_CLKMON = 2'h2;
    localparam logic [1:0] CAUSE_POR = 2'h3;
    typedef enum logic [1:0] {RS_IDLE, RS_DRIVE, RS_WAIT} irc_rst_t;
endpackage

// ---- rtl/irc_top.sv ----
// Interrupt and reset control: request latching, priority, vectors, reset source.
// Assumes E-clock enable from a divider, register port strobes on the same clock,
// and the CPU supplies its I and X mask bits and a service start pulse.
//
// Summary of operation
// - Non-maskable pin level sensed, X gated
// - No source left at service: trap vector
// - Edge mode latches falling edge; service clears
// - Other sources held in flags until cleared
// - Fixed reset vectors per reset cause
// - Pin request FFF2 via connect; tick FFF0
// - Timer group vectors FFEE down to FFDA
// - Serial, converter, link vectors; D4 reserved
// - Counter vectors; reserved slots; unimplemented range
// - Default priority: higher vector wins
// - Priority register written only with I set
// - Written low byte raises source; invalid uses F2
// - Edge select once normal; special skips first
// - Edge select one falling, zero low level
// - Connect bit always writable, gates pin
// - Stop delay bit; 4096 E-clock exit delay
// - Reset entry asynchronous for i_sys_rst only; POR and external share FFFE
// - Drive pin 16, release, sample after 8
// - Bad key or timeout: watchdog reset
// - Clock monitor fault raises reset when enabled
// - Reset: priority F2, level mode
`timescale 1ns/1ps
`default_nettype none
module irc_top #(
    parameter int WDOG_TIMEOUT = 65536,
    parameter int STOP_DELAY = irc_pkg::STOP_DELAY_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_e_clk_en,
    input wire logic i_special_mode,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_i_mask,
    input wire logic i_x_mask,
    input wire logic i_svc_start,
    input wire logic i_swi,
    input wire logic i_nonmaskable_pin_request_n,
    input wire logic i_ext_irq_n,
    input wire logic [irc_pkg::NSRC-1:0] i_src_set,
    input wire logic i_clk_fail,
    input wire logic i_reset_pin,
    input wire logic i_stop_exit,
    output logic o_reset_pin_o,
    output logic o_reset_pin_oe,
    output logic o_int_req,
    output logic [15:0] o_vector,
    output logic o_vector_valid,
    output logic o_stop_release,
    output logic o_core_rst
);
    logic [7:0] pin_ctrl_r;
    logic [7:0] prio_r;
    logic [7:0] wdog_ctrl_r;
    logic edge_written_r;
    logic delay_written_r;
    logic [1:0] cause_r;
    logic [irc_pkg::NSRC-1:0] flag_r;
    logic [1:0] nmi_sync_r;
    logic [1:0] irq_sync_r;
    logic [1:0] rstp_sync_r;
    logic [1:0] clkf_sync_r;
    logic irq_prev_r;
    logic edge_latch_r;
    logic wdog_armed_r;
    logic [31:0] wdog_cnt_r;
    logic wdog_fire;
    irc_pkg::irc_rst_t rst_state_r;
    logic [4:0] rst_cnt_r;
    logic [1:0] pend_cause_r;
    logic [12:0] stop_cnt_r;
    logic stop_busy_r;

    wire wr_pin = i_wr && i_addr == irc_pkg::ADDR_PIN_CTRL;
    wire wr_wsvc = i_wr && i_addr == irc_pkg::ADDR_WDOG_SVC;
    wire clkmon_on = wdog_ctrl_r[6] | wdog_ctrl_r[5];
    wire clk_fault = clkmon_on && clkf_sync_r[1];

    // Input synchronisers
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            nmi_sync_r <= 2'h3;
            irq_sync_r <= 2'h3;
            rstp_sync_r <= 2'h3;
            clkf_sync_r <= 2'h0;
        end else begin
            nmi_sync_r <= {nmi_sync_r[0], i_nonmaskable_pin_request_n};
            irq_sync_r <= {irq_sync_r[0], i_ext_irq_n};
            rstp_sync_r <= {rstp_sync_r[0], i_reset_pin};
            clkf_sync_r <= {clkf_sync_r[0], i_clk_fail};
        end
    end

    // Pin control register
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pin_ctrl_r <= irc_pkg::PIN_CTRL_RST;
            edge_written_r <= 1'b0;
            delay_written_r <= 1'b0;
        end else if (wr_pin) begin
            pin_ctrl_r[irc_pkg::BIT_CONNECT] <= i_wdata[irc_pkg::BIT_CONNECT];
            edge_written_r <= 1'b1;
            // Normal: first write lands, later ignored; special: first ignored
            if (i_special_mode ? edge_written_r : !edge_written_r) begin
                pin_ctrl_r[irc_pkg::BIT_EDGE] <= i_wdata[irc_pkg::BIT_EDGE];
            end
            delay_written_r <= 1'b1;
            if (i_special_mode || !delay_written_r) begin
                pin_ctrl_r[irc_pkg::BIT_DELAY] <= i_wdata[irc_pkg::BIT_DELAY];
            end
        end
    end

    // Priority override register
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            prio_r <= irc_pkg::PRIO_RST;
        end else if (i_wr && i_addr == irc_pkg::ADDR_PRIO && i_i_mask) begin
            prio_r <= i_wdata;
        end
    end

    // Watchdog control and service sequence
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wdog_ctrl_r <= irc_pkg::WDOG_CTRL_RST;
            wdog_armed_r <= 1'b0;
            wdog_cnt_r <= 32'h0;
        end else if (o_core_rst) begin
            // Any reset restarts the watchdog and turns the monitor off
            wdog_ctrl_r <= irc_pkg::WDOG_CTRL_RST;
            wdog_armed_r <= 1'b0;
            wdog_cnt_r <= 32'h0;
        end else begin
            if (i_wr && i_addr == irc_pkg::ADDR_WDOG_CTRL) begin
                wdog_ctrl_r <= i_wdata;
            end
            if (wr_wsvc && i_wdata == irc_pkg::WDOG_KEY1) begin
                wdog_armed_r <= 1'b1;
            end else if (wr_wsvc && i_wdata == irc_pkg::WDOG_KEY2 && wdog_armed_r) begin
                wdog_armed_r <= 1'b0;
                wdog_cnt_r <= 32'h0;
            end else if (wdog_ctrl_r[7] && i_e_clk_en) begin
                wdog_cnt_r <= wdog_cnt_r + 32'h1;
            end
        end
    end

    // Bad key, AA without 55, or timeout
    assign wdog_fire = wdog_ctrl_r[7] && ((wr_wsvc && i_wdata != irc_pkg::WDOG_KEY1
        && !(i_wdata == irc_pkg::WDOG_KEY2 && wdog_armed_r))
        || wdog_cnt_r >= 32'(WDOG_TIMEOUT));

    // Reset pin sequencer and cause capture
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rst_state_r <= irc_pkg::RS_DRIVE;
            rst_cnt_r <= 5'h0;
            pend_cause_r <= irc_pkg::CAUSE_POR;
            cause_r <= irc_pkg::CAUSE_POR;
            o_reset_pin_oe <= 1'b1;
            o_core_rst <= 1'b1;
        end else begin
            case (rst_state_r)
                irc_pkg::RS_IDLE: begin
                    if (clk_fault || wdog_fire || !rstp_sync_r[1]) begin
                        // Clock monitor outranks watchdog, then the pin
                        if (clk_fault) begin
                            pend_cause_r <= irc_pkg::CAUSE_CLKMON;
                        end else if (wdog_fire) begin
                            pend_cause_r <= irc_pkg::CAUSE_WDOG;
                        end else begin
                            pend_cause_r <= irc_pkg::CAUSE_EXT;
                        end
                        rst_state_r <= irc_pkg::RS_DRIVE;
                        rst_cnt_r <= 5'h0;
                        o_reset_pin_oe <= 1'b1;
                        o_core_rst <= 1'b1;
                    end
                end
                irc_pkg::RS_DRIVE: begin
                    if (i_e_clk_en) begin
                        rst_cnt_r <= rst_cnt_r + 5'h1;
                        if (rst_cnt_r == 5'(irc_pkg::RST_DRIVE_CYC - 1)) begin
                            o_reset_pin_oe <= 1'b0;
                            rst_cnt_r <= 5'h0;
                            rst_state_r <= irc_pkg::RS_WAIT;
                        end
                    end
                end
                irc_pkg::RS_WAIT: begin
                    if (i_e_clk_en) begin
                        rst_cnt_r <= rst_cnt_r + 5'h1;
                        if (rst_cnt_r == 5'(irc_pkg::RST_SAMPLE_CYC - 1)) begin
                            // Low sample means external; otherwise the pending cause
                            if (!rstp_sync_r[1]) begin
                                cause_r <= irc_pkg::CAUSE_EXT;
                            end else begin
                                cause_r <= pend_cause_r;
                            end
                            o_core_rst <= 1'b0;
                            rst_state_r <= irc_pkg::RS_IDLE;
                        end
                    end
                end
                default: rst_state_r <= irc_pkg::RS_IDLE;
            endcase
        end
    end

    // Stop exit stabilisation delay
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            stop_busy_r <= 1'b0;
            stop_cnt_r <= 13'h0;
            o_stop_release <= 1'b0;
        end else begin
            o_stop_release <= 1'b0;
            if (i_stop_exit && !stop_busy_r) begin
                if (pin_ctrl_r[irc_pkg::BIT_DELAY]) begin
                    stop_busy_r <= 1'b1;
                    stop_cnt_r <= 13'h0;
                end else begin
                    o_stop_release <= 1'b1;
                end
            end else if (stop_busy_r && i_e_clk_en) begin
                stop_cnt_r <= stop_cnt_r + 13'h1;
                if (stop_cnt_r == 13'(STOP_DELAY - 1)) begin
                    stop_busy_r <= 1'b0;
                    o_stop_release <= 1'b1;
                end
            end
        end
    end

    // Pending request selection
    logic [7:0] win_low;
    logic win_any;
    logic pin_pend;
    always_comb begin
        win_low = irc_pkg::LOW_EXT_PIN;
        win_any = 1'b0;
        pin_pend = pin_ctrl_r[irc_pkg::BIT_CONNECT] &&
            (pin_ctrl_r[irc_pkg::BIT_EDGE] ? edge_latch_r : !irq_sync_r[1]);
        // Lowest index scanned last wins: higher vector has priority
        for (int k = irc_pkg::NSRC - 1; k >= 0; k--) begin
            if (flag_r[k]) begin
                win_any = 1'b1;
                win_low = 8'(irc_pkg::LOW_TOP - 8'(2 * k));
            end
        end
        if (pin_pend) begin
            win_any = 1'b1;
            win_low = irc_pkg::LOW_EXT_PIN;
        end
        // Override only for a valid implemented maskable slot
        for (int k = 0; k < irc_pkg::NSRC; k++) begin
            if (flag_r[k] && prio_r == 8'(irc_pkg::LOW_TOP - 8'(2 * k))
                && prio_r != irc_pkg::LOW_RESERVED_D4) begin
                win_low = prio_r;
            end
        end
    end

    wire nmi_pend = !nmi_sync_r[1] && !i_x_mask;
    wire mask_pend = win_any && !i_i_mask;

    // Edge latch and source flags
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_prev_r <= 1'b1;
            edge_latch_r <= 1'b0;
            flag_r <= '0;
        end else begin
            irq_prev_r <= irq_sync_r[1];
            // Falling edges latch only in edge mode
            if (pin_ctrl_r[irc_pkg::BIT_EDGE] && irq_prev_r && !irq_sync_r[1]) begin
                edge_latch_r <= 1'b1;
            end else if (i_svc_start && !nmi_pend && !i_swi && mask_pend
                && win_low == irc_pkg::LOW_EXT_PIN) begin
                edge_latch_r <= 1'b0;
            end
            for (int k = 0; k < irc_pkg::NSRC; k++) begin
                if (i_src_set[k]) begin
                    flag_r[k] <= 1'b1;
                end else if (i_wr && i_wdata[k % 8] && i_addr ==
                    4'(irc_pkg::ADDR_FLAG_CLR_LO + 4'(k / 8))) begin
                    flag_r[k] <= 1'b0;
                end
            end
        end
    end

    // Vector presented at service start
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_vector <= irc_pkg::VEC_RESET;
            o_vector_valid <= 1'b0;
            o_int_req <= 1'b0;
        end else begin
            o_int_req <= nmi_pend || mask_pend;
            o_vector_valid <= 1'b0;
            if (o_core_rst) begin
                // Follows the cause being decided, so it is right as reset ends
                if (!rstp_sync_r[1]) begin
                    o_vector <= irc_pkg::VEC_RESET;
                end else begin
                    case (pend_cause_r)
                        irc_pkg::CAUSE_CLKMON: o_vector <= irc_pkg::VEC_CLKMON;
                        irc_pkg::CAUSE_WDOG: o_vector <= irc_pkg::VEC_WDOG;
                        default: o_vector <= irc_pkg::VEC_RESET;
                    endcase
                end
            end else if (i_svc_start) begin
                o_vector_valid <= 1'b1;
                if (i_swi) begin
                    o_vector <= 16'hFFF6;
                end else if (nmi_pend) begin
                    o_vector <= irc_pkg::VEC_NMI;
                end else if (mask_pend) begin
                    o_vector <= {irc_pkg::VEC_HI_BYTE, win_low};
                end else begin
                    o_vector <= irc_pkg::VEC_TRAP;
                end
            end
        end
    end

    // Register read port
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                irc_pkg::ADDR_PIN_CTRL: o_rdata <= pin_ctrl_r;
                irc_pkg::ADDR_PRIO: o_rdata <= prio_r;
                irc_pkg::ADDR_WDOG_CTRL: o_rdata <= wdog_ctrl_r;
                irc_pkg::ADDR_RST_STAT: o_rdata <= {6'h00, cause_r};
                irc_pkg::ADDR_PEND_LO: o_rdata <= flag_r[7:0];
                irc_pkg::ADDR_PEND_MID: o_rdata <= flag_r[15:8];
                irc_pkg::ADDR_PEND_HI: o_rdata <= flag_r[23:16];
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // Open-drain pin: only ever pulled low, the enable does the work
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reset_pin_o <= 1'b0;
        end else begin
            o_reset_pin_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- verif/irc_top_props.sv ----
// Concurrent checks on the reset sequencer and the vector port.
// Assumes the ports of irc_top and one reference clock domain.
`timescale 1ns/1ps
`default_nettype none
module irc_top_props (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_e_clk_en,
    input wire logic i_svc_start,
    input wire logic i_swi,
    input wire logic o_reset_pin_o,
    input wire logic o_reset_pin_oe,
    input wire logic o_int_req,
    input wire logic [15:0] o_vector,
    input wire logic o_vector_valid,
    input wire logic o_stop_release,
    input wire logic o_core_rst
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    logic [7:0] drv_cnt_r;
    logic [7:0] smp_cnt_r;
    // E-clocks spent driving the pin, then waiting for the sample
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) drv_cnt_r <= 8'h00;
        else if (!o_reset_pin_oe) drv_cnt_r <= 8'h00;
        else if (i_e_clk_en) drv_cnt_r <= drv_cnt_r + 8'h01;
    end
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) smp_cnt_r <= 8'h00;
        else if (o_reset_pin_oe) smp_cnt_r <= 8'h00;
        else if (o_core_rst && i_e_clk_en) smp_cnt_r <= smp_cnt_r + 8'h01;
    end
    sequence s_pin_release;
        $fell(o_reset_pin_oe);
    endsequence
    sequence s_svc_idle;
        i_svc_start && !o_int_req && !i_swi;
    endsequence
    a_pin_drive_low: assert property (o_reset_pin_o == 1'b0)
        else $error("reset pin driven high");
    a_drive_length: assert property (s_pin_release |-> drv_cnt_r inside {[8'h0F:8'h11]})
        else $error("reset pin drive length wrong");
    a_sample_wait: assert property ($fell(o_core_rst) |-> smp_cnt_r inside {[8'h07:8'h0A]})
        else $error("reset sample wait wrong");
    a_core_holds: assert property (s_pin_release |-> o_core_rst [*6])
        else $error("core reset left before sample");
    a_drive_in_rst: assert property (o_reset_pin_oe |-> o_core_rst)
        else $error("pin driven outside reset");
    a_trap_empty: assert property (s_svc_idle |=> o_vector_valid
        && o_vector == irc_pkg::VEC_TRAP)
        else $error("trap vector not given");
    a_valid_cause: assert property (o_vector_valid && !$past(o_core_rst) |-> $past(i_svc_start))
        else $error("vector without service");
    a_vector_range: assert property (o_vector_valid |-> o_vector[15:8] == 8'hFF
        && !o_vector[0] && o_vector[7:0] >= 8'hC2)
        else $error("vector outside table");
    a_valid_pulse: assert property (o_vector_valid |=> !o_vector_valid)
        else $error("vector valid too long");
    a_stop_pulse: assert property (o_stop_release |=> !o_stop_release)
        else $error("stop release too long");
endmodule
bind irc_top irc_top_props irc_top_props_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_e_clk_en(i_e_clk_en), .i_svc_start(i_svc_start), .i_swi(i_swi),
    .o_reset_pin_o(o_reset_pin_o), .o_reset_pin_oe(o_reset_pin_oe), .o_int_req(o_int_req),
    .o_vector(o_vector), .o_vector_valid(o_vector_valid), .o_stop_release(o_stop_release),
    .o_core_rst(o_core_rst));
`default_nettype wire

// ---- verif/irc_far_model.sv ----
// Pins outside the block: reset pin with pull-up and a level interrupt source.
// Assumes the bench commands request, acknowledge and external reset.
`timescale 1ns/1ps
`default_nettype none
module irc_far_model (
    input wire logic i_clk,
    input wire logic i_pin_oe,
    input wire logic i_ext_rst,
    input wire logic i_irq_req,
    input wire logic i_irq_ack,
    output logic o_reset_pin,
    output logic o_irq_n
);
    logic irq_hold_r = 1'b0;
    // Source keeps the pin low until the handler acknowledges
    always_ff @(posedge i_clk) begin
        if (i_irq_ack) irq_hold_r <= 1'b0;
        else if (i_irq_req) irq_hold_r <= 1'b1;
    end
    assign o_irq_n = !irq_hold_r;
    // Pulled up unless the block or the external source pulls low
    assign o_reset_pin = !(i_pin_oe || i_ext_rst);
endmodule
`default_nettype wire

// ---- verif/interrupt_and_reset_control_tb_top.sv ----
// Self-checking bench for irc_top with the far-side pin model.
// Assumes the E-clock enable runs at half the reference clock.
`timescale 1ns/1ps
`default_nettype none
module interrupt_and_reset_control_tb_top;
    typedef struct packed {logic [3:0] a; logic [7:0] d; logic im;
        logic [7:0] m; logic [7:0] e;} irc_row_t;
    localparam irc_row_t ROWS [8] = '{
        '{4'h0, 8'h00, 1'b1, 8'hE0, 8'h00}, '{4'h0, 8'hE0, 1'b1, 8'hE0, 8'h40},
        '{4'h0, 8'h00, 1'b1, 8'h40, 8'h00}, '{4'h0, 8'h40, 1'b1, 8'h40, 8'h40},
        '{4'h1, 8'hF0, 1'b1, 8'hFF, 8'hF0}, '{4'h1, 8'hEE, 1'b0, 8'hFF, 8'hF0},
        '{4'h1, 8'hF8, 1'b1, 8'hFF, 8'hF8}, '{4'h1, 8'hCC, 1'b1, 8'hFF, 8'hCC}};
    logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_e_clk_en = 1'b0, i_special_mode = 1'b0;
    logic i_wr = 1'b0, i_rd = 1'b0, i_i_mask = 1'b1, i_x_mask = 1'b1, i_svc_start = 1'b0;
    logic i_swi = 1'b0, i_nonmaskable_pin_request_n = 1'b1, i_clk_fail = 1'b0, i_stop_exit = 1'b0;
    logic ext_rst = 1'b0, irq_req = 1'b0, irq_ack = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic [23:0] i_src_set = 24'h000000;
    logic i_reset_pin, i_ext_irq_n, o_reset_pin_o, o_reset_pin_oe, o_int_req, o_vector_valid;
    logic o_stop_release, o_core_rst;
    logic [7:0] o_rdata;
    logic [15:0] o_vector;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    irc_top #(.WDOG_TIMEOUT(64), .STOP_DELAY(16)) irc_top_inst (.*);
    irc_far_model irc_far_model_inst (.i_clk(i_ref_clk), .i_pin_oe(o_reset_pin_oe),
        .i_ext_rst(ext_rst), .i_irq_req(irq_req), .i_irq_ack(irq_ack),
        .o_reset_pin(i_reset_pin), .o_irq_n(i_ext_irq_n));
    initial begin
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        i_e_clk_en <= ~i_e_clk_en;
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        @(negedge i_ref_clk);
        d = o_rdata;
    endtask
    task automatic svc_chk(input logic [15:0] exp);
        @(posedge i_ref_clk);
        i_svc_start <= 1'b1;
        @(posedge i_ref_clk);
        i_svc_start <= 1'b0;
        @(negedge i_ref_clk);
        chk(16'(o_vector_valid), 16'h0001);
        chk(o_vector, exp);
    endtask
    task automatic pin_evt(input bit req);
        @(posedge i_ref_clk);
        if (req) irq_req <= 1'b1;
        else irq_ack <= 1'b1;
        @(posedge i_ref_clk);
        irq_req <= 1'b0;
        irq_ack <= 1'b0;
        repeat (6) @(posedge i_ref_clk);
    endtask
    task automatic wait_lvl(input logic v);
        int n;
        n = 0;
        while (o_core_rst !== v) begin
            @(negedge i_ref_clk);
            n++;
            if (n > 500) begin
                error_cnt++;
                conclude();
            end
        end
    endtask
    task automatic rst_done(input logic [1:0] cause);
        logic [7:0] d;
        wait_lvl(1'b1);
        wait_lvl(1'b0);
        rd_reg(irc_pkg::ADDR_RST_STAT, d);
        chk(16'(d[1:0]), 16'(cause));
        chk(o_vector, cause == irc_pkg::CAUSE_CLKMON ? irc_pkg::VEC_CLKMON :
            cause == irc_pkg::CAUSE_WDOG ? irc_pkg::VEC_WDOG : irc_pkg::VEC_RESET);
        wr_reg(irc_pkg::ADDR_WDOG_CTRL, 8'h00);
        $display("test reset cause %0d done", cause);
    endtask
    initial begin
        int n;
        logic [7:0] d;
        repeat (12) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        rst_done(irc_pkg::CAUSE_POR);
        rd_reg(irc_pkg::ADDR_PIN_CTRL, d);
        chk(16'(d & 8'hE0), 16'h0060);
        rd_reg(irc_pkg::ADDR_PRIO, d);
        chk(16'(d), 16'h00F2);
        @(posedge i_ref_clk);
        i_stop_exit <= 1'b1;
        @(posedge i_ref_clk);
        i_stop_exit <= 1'b0;
        n = 0;
        while (o_stop_release !== 1'b1 && n < 100) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk(16'(n >= 28 && n <= 40), 16'h0001);
        @(posedge i_ref_clk);
        i_src_set <= 24'hFFBFFF;
        @(posedge i_ref_clk);
        i_src_set <= 24'h000000;
        foreach (ROWS[i]) begin
            @(posedge i_ref_clk);
            i_i_mask <= ROWS[i].im;
            wr_reg(ROWS[i].a, ROWS[i].d);
            rd_reg(ROWS[i].a, d);
            chk(16'(d & ROWS[i].m), 16'(ROWS[i].e));
            $display("test row %0d done", i);
        end
        @(posedge i_ref_clk);
        i_i_mask <= 1'b0;
        svc_chk(16'hFFCC);
        wr_reg(irc_pkg::ADDR_FLAG_CLR_HI, 8'h04);
        for (int k = 0; k < 24; k++) begin
            if (k != 14 && k != 18) begin
                svc_chk({8'hFF, 8'hF0 - 8'(2 * k)});
                wr_reg(4'(irc_pkg::ADDR_FLAG_CLR_LO + k / 8), 8'h01 << (k % 8));
            end
        end
        svc_chk(irc_pkg::VEC_TRAP);
        pin_evt(1'b1);
        svc_chk(16'hFFF2);
        svc_chk(16'hFFF2);
        pin_evt(1'b0);
        svc_chk(irc_pkg::VEC_TRAP);
        wr_reg(irc_pkg::ADDR_PIN_CTRL, 8'h00);
        pin_evt(1'b1);
        svc_chk(irc_pkg::VEC_TRAP);
        pin_evt(1'b0);
        @(posedge i_ref_clk);
        i_nonmaskable_pin_request_n <= 1'b0;
        i_x_mask <= 1'b0;
        repeat (6) @(posedge i_ref_clk);
        svc_chk(irc_pkg::VEC_NMI);
        chk(16'(o_int_req), 16'h0001);
        @(posedge i_ref_clk);
        i_x_mask <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        svc_chk(irc_pkg::VEC_TRAP);
        chk(16'(o_int_req), 16'h0000);
        @(posedge i_ref_clk);
        i_nonmaskable_pin_request_n <= 1'b1;
        $display("test service done");
        wr_reg(irc_pkg::ADDR_WDOG_CTRL, 8'h80);
        wr_reg(irc_pkg::ADDR_WDOG_SVC, 8'h55);
        wr_reg(irc_pkg::ADDR_WDOG_SVC, 8'hAA);
        repeat (4) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        chk(16'(o_core_rst), 16'h0000);
        wr_reg(irc_pkg::ADDR_WDOG_SVC, 8'h12);
        rst_done(irc_pkg::CAUSE_WDOG);
        wr_reg(irc_pkg::ADDR_WDOG_CTRL, 8'h80);
        rst_done(irc_pkg::CAUSE_WDOG);
        wr_reg(irc_pkg::ADDR_WDOG_CTRL, 8'h40);
        i_clk_fail <= 1'b1;
        rst_done(irc_pkg::CAUSE_CLKMON);
        i_clk_fail <= 1'b0;
        ext_rst <= 1'b1;
        repeat (80) @(posedge i_ref_clk);
        ext_rst <= 1'b0;
        rst_done(irc_pkg::CAUSE_EXT);
        i_sys_rst <= 1'b1;
        i_special_mode <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        rst_done(irc_pkg::CAUSE_POR);
        wr_reg(irc_pkg::ADDR_PIN_CTRL, 8'hC0);
        rd_reg(irc_pkg::ADDR_PIN_CTRL, d);
        chk(16'(d & 8'h80), 16'h0000);
        wr_reg(irc_pkg::ADDR_PIN_CTRL, 8'hC0);
        rd_reg(irc_pkg::ADDR_PIN_CTRL, d);
        chk(16'(d & 8'h80), 16'h0080);
        pin_evt(1'b1);
        pin_evt(1'b0);
        i_i_mask <= 1'b0;
        svc_chk(16'hFFF2);
        svc_chk(irc_pkg::VEC_TRAP);
        $display("test edge mode done");
        conclude();
    end
endmodule
`default_nettype wire
